// >>> hdl/i2c_irq_pkg.sv
/*
 * Constants of the two-wire controller's raw interrupt status block.
 * Assumes one 250 MHz clock shared with the FIFO datapath and the protocol engine.
 */
`default_nettype none

package i2c_irq_pkg;

    localparam int FIFO_DEPTH = 16;
    localparam int THR_W      = 10;
    localparam int LEN_W      = 11;

    localparam logic [7:0] CTRL_ADDR  = 8'h00;
    localparam logic [7:0] MLEN_ADDR  = 8'h08;
    localparam logic [7:0] SLEN_ADDR  = 8'h0c;
    localparam logic [7:0] TXTHR_ADDR = 8'h18;
    localparam logic [7:0] RXTHR_ADDR = 8'h1c;
    localparam logic [7:0] MASK_ADDR  = 8'h2c;
    localparam logic [7:0] RAW_ADDR   = 8'h30;
    localparam logic [7:0] CLR_ADDR   = 8'h38;

    localparam int TXE_BIT  = 0;
    localparam int TXLO_BIT = 1;
    localparam int TXF_BIT  = 2;
    localparam int TXOV_BIT = 3;
    localparam int RXE_BIT  = 4;
    localparam int RXHI_BIT = 5;
    localparam int RXF_BIT  = 6;
    localparam int LEN_BIT  = 15;
    localparam int RREQ_BIT = 16;
    localparam int RUND_BIT = 17;
    localparam int WREQ_BIT = 18;

    localparam int FLUSH_BIT = 0;
    localparam int HOLD_BIT  = 1;

    localparam logic [31:0] RAW_RESET   = 32'h0000_0013;
    localparam logic [31:0] MASK_BITS   = 32'h0007_807f;
    localparam logic [31:0] STICKY_BITS = 32'h0005_8008;
    localparam logic [31:0] CTRL_BITS   = 32'h0000_0003;
    localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;

    localparam int SYNC_STAGES = 2;

endpackage

`default_nettype wire

// >>> hdl/length_match_counter.sv
/*
 * Counts received bytes of one transfer and flags the byte that reaches the length.
 * Assumes byte strobes and the active level come from logic on the same clock.
 */
`default_nettype none

module length_match_counter
    import i2c_irq_pkg::*;
#(
    parameter int LW = LEN_W
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic          active_i,
    input  wire logic          byte_i,
    input  wire logic [LW-1:0] length_i,
    output logic               hit_o
);

    logic [LW-1:0] count;
    logic [LW-1:0] next_count;
    wire           match;

    // The count restarts with every transfer and matches on the byte that makes it equal.
    assign next_count = count + LW'(1);
    assign match      = active_i && byte_i && (next_count == length_i);

    always_ff @(posedge clk_i) begin
        if (rst_i || !active_i) begin
            count <= '0;
        end else if (byte_i) begin
            count <= next_count;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hit_o <= 1'b0;
        end else begin
            hit_o <= match;
        end
    end

    a_count_match: assert property (@(posedge clk_i) disable iff (rst_i)
        active_i && byte_i && (count + LW'(1) == length_i) |=> hit_o)
        else $error("Length match not flagged on the matching byte.");

endmodule

`default_nettype wire

// >>> hdl/i2c_raw_interrupt_status.sv
/*
 * Raw interrupt status, mask, clear and clock hold of a two-wire serial controller.
 * Assumes FIFO counts, strobes and slave events come from logic on clk_i, and that
 * the serial clock pin is open drain, resolved outside from scl_oe_o.
 */
`default_nettype none

module i2c_raw_interrupt_status
    import i2c_irq_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH,
    parameter int CW    = $clog2(DEPTH + 1)
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic             wb_ack_o,
    input  wire logic [CW-1:0] tx_count_i,
    input  wire logic [CW-1:0] rx_count_i,
    input  wire logic        tx_write_i,
    input  wire logic        rx_read_i,
    input  wire logic        rx_byte_i,
    input  wire logic        master_read_op_i,
    input  wire logic        slave_write_op_i,
    input  wire logic        slave_read_req_i,
    input  wire logic        slave_write_req_i,
    input  wire logic        slave_read_busy_i,
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe_o,
    output logic             tx_flush_o,
    output logic             irq_o
);

    // ************************************************************
    // Register bus
    // ************************************************************

    wire  [31:0]      raw;
    logic [31:0]      mask;
    logic [31:0]      ctrl;
    logic [LEN_W-1:0] master_len;
    logic [LEN_W-1:0] slave_len;
    logic [THR_W-1:0] tx_thr;
    logic [THR_W-1:0] rx_thr;
    logic [31:0]      next_rdata;

    wire        bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire        bus_wr  = bus_req && wb_we_i;
    wire [31:0] lanes   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                           {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [31:0] wbits   = wb_dat_i & lanes;
    wire        wr_ctrl = bus_wr && (wb_adr_i == CTRL_ADDR);
    wire        wr_mlen = bus_wr && (wb_adr_i == MLEN_ADDR);
    wire        wr_slen = bus_wr && (wb_adr_i == SLEN_ADDR);
    wire        wr_txt  = bus_wr && (wb_adr_i == TXTHR_ADDR);
    wire        wr_rxt  = bus_wr && (wb_adr_i == RXTHR_ADDR);
    wire        wr_mask = bus_wr && (wb_adr_i == MASK_ADDR);
    wire        wr_clr  = bus_wr && (wb_adr_i == CLR_ADDR);
    wire [31:0] clr     = wr_clr ? (wbits & STICKY_BITS) : ZERO_WORD;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] keep);
        merge = (old & ~(lanes & keep)) | (wb_dat_i & lanes & keep);
    endfunction

    always_comb begin
        next_rdata = ZERO_WORD;
        unique case (wb_adr_i)
            CTRL_ADDR:  next_rdata = ctrl;
            MLEN_ADDR:  next_rdata = 32'(master_len);
            SLEN_ADDR:  next_rdata = 32'(slave_len);
            TXTHR_ADDR: next_rdata = 32'(tx_thr);
            RXTHR_ADDR: next_rdata = 32'(rx_thr);
            MASK_ADDR:  next_rdata = mask;
            RAW_ADDR:   next_rdata = raw;
            default:    next_rdata = ZERO_WORD;
        endcase
    end

    // Every access, mapped or not, is acknowledged one cycle after the request.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= ZERO_WORD;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= (bus_req && !wb_we_i) ? next_rdata : ZERO_WORD;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask <= ZERO_WORD;
        end else if (wr_mask) begin
            mask <= merge(mask, MASK_BITS);
        end
    end

    // The flush bit reads back as zero: it only fires one flush pulse.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= ZERO_WORD;
        end else if (wr_ctrl) begin
            ctrl <= merge(ctrl, CTRL_BITS) & ~(32'h0000_0001 << FLUSH_BIT);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            master_len <= '0;
            slave_len  <= '0;
            tx_thr     <= '0;
            rx_thr     <= '0;
        end else begin
            if (wr_mlen) master_len <= LEN_W'(merge(32'(master_len), ~ZERO_WORD));
            if (wr_slen) slave_len <= LEN_W'(merge(32'(slave_len), ~ZERO_WORD));
            if (wr_txt) tx_thr <= THR_W'(merge(32'(tx_thr), ~ZERO_WORD));
            if (wr_rxt) rx_thr <= THR_W'(merge(32'(rx_thr), ~ZERO_WORD));
        end
    end

    // ************************************************************
    // Level flags
    // ************************************************************

    wire tx_empty = (tx_count_i == '0);
    wire rx_empty = (rx_count_i == '0);
    wire tx_full  = (tx_count_i == CW'(DEPTH));
    wire rx_full  = (rx_count_i == CW'(DEPTH));
    wire tx_low   = (32'(tx_count_i) <= 32'(tx_thr));
    wire rx_high  = (32'(rx_count_i) >= 32'(rx_thr));

    logic tx_fifo_empty_flag;
    logic tx_fifo_low_level_flag;
    logic tx_fifo_full_flag;
    logic tx_fifo_overflow_flag;
    logic rx_fifo_empty_flag;
    logic rx_fifo_high_level_flag;
    logic rx_fifo_full_flag;
    logic length_reached_flag;
    logic slave_read_request_flag;
    logic slave_read_underflow_flag;
    logic slave_write_request_flag;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_fifo_empty_flag        <= RAW_RESET[TXE_BIT];
            tx_fifo_low_level_flag    <= RAW_RESET[TXLO_BIT];
            tx_fifo_full_flag         <= RAW_RESET[TXF_BIT];
            rx_fifo_empty_flag        <= RAW_RESET[RXE_BIT];
            rx_fifo_high_level_flag   <= RAW_RESET[RXHI_BIT];
            slave_read_underflow_flag <= RAW_RESET[RUND_BIT];
        end else begin
            tx_fifo_empty_flag        <= tx_empty;
            tx_fifo_low_level_flag    <= tx_low;
            tx_fifo_full_flag         <= tx_full;
            rx_fifo_empty_flag        <= rx_empty;
            rx_fifo_high_level_flag   <= rx_high;
            slave_read_underflow_flag <= slave_read_busy_i && tx_empty;
        end
    end

    // Full sets when reached and holds until a read takes data out; set wins.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_fifo_full_flag <= RAW_RESET[RXF_BIT];
        end else begin
            rx_fifo_full_flag <= rx_full || (rx_fifo_full_flag && !rx_read_i);
        end
    end

    // ************************************************************
    // Sticky flags
    // ************************************************************

    logic len_hit;
    wire  len_active = master_read_op_i || slave_write_op_i;
    wire  [LEN_W-1:0] len_sel = master_read_op_i ? master_len : slave_len;
    wire  tx_ovf_ev = tx_write_i && tx_full;

    length_match_counter #(
        .LW(LEN_W)
    ) u_len (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .active_i(len_active),
        .byte_i  (rx_byte_i),
        .length_i(len_sel),
        .hit_o   (len_hit)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_fifo_overflow_flag    <= RAW_RESET[TXOV_BIT];
            length_reached_flag      <= RAW_RESET[LEN_BIT];
            slave_write_request_flag <= RAW_RESET[WREQ_BIT];
            slave_read_request_flag  <= RAW_RESET[RREQ_BIT];
        end else begin
            tx_fifo_overflow_flag    <= tx_ovf_ev
                || (tx_fifo_overflow_flag && !clr[TXOV_BIT]);
            length_reached_flag      <= len_hit
                || (length_reached_flag && !clr[LEN_BIT]);
            slave_write_request_flag <= slave_write_req_i
                || (slave_write_request_flag && !clr[WREQ_BIT]);
            slave_read_request_flag  <= slave_read_req_i
                || (slave_read_request_flag && !clr[RREQ_BIT] && !tx_write_i);
        end
    end

    // The status word gathers every flag at its bit; unused positions stay zero.
    assign raw[TXE_BIT]  = tx_fifo_empty_flag;
    assign raw[TXLO_BIT] = tx_fifo_low_level_flag;
    assign raw[TXF_BIT]  = tx_fifo_full_flag;
    assign raw[TXOV_BIT] = tx_fifo_overflow_flag;
    assign raw[RXE_BIT]  = rx_fifo_empty_flag;
    assign raw[RXHI_BIT] = rx_fifo_high_level_flag;
    assign raw[RXF_BIT]  = rx_fifo_full_flag;
    assign raw[LEN_BIT]  = length_reached_flag;
    assign raw[RREQ_BIT] = slave_read_request_flag;
    assign raw[RUND_BIT] = slave_read_underflow_flag;
    assign raw[WREQ_BIT] = slave_write_request_flag;
    assign raw[14:7]     = '0;
    assign raw[31:19]    = '0;

    // ************************************************************
    // Flush, interrupt and clock hold
    // ************************************************************

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_flush_o <= 1'b0;
        end else begin
            tx_flush_o <= slave_read_req_i || (wr_ctrl && wbits[FLUSH_BIT]);
        end
    end

    assign irq_o = |(raw & mask);

    logic [SYNC_STAGES-1:0] scl_sync;
    logic                   holding;
    wire                    scl_low   = !scl_sync[SYNC_STAGES-1];
    wire                    hold_want = raw[LEN_BIT] && ctrl[HOLD_BIT];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scl_sync <= '1;
        end else begin
            scl_sync <= {scl_sync[SYNC_STAGES-2:0], scl_i};
        end
    end

    // The hold is taken only while the line is already low, so no high phase is cut short.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            holding <= 1'b0;
        end else begin
            holding <= hold_want && (holding || scl_low);
        end
    end

    assign scl_o    = 1'b0;
    assign scl_oe_o = holding;

    // ************************************************************
    // Checks
    // ************************************************************

    sequence s_ovf_write;
        tx_write_i && tx_full;
    endsequence

    sequence s_clear_len;
        wr_clr && wbits[LEN_BIT] && !len_hit;
    endsequence

    a_tx_empty_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        raw[TXE_BIT] == $past(tx_empty))
        else $error("Transmit empty flag does not follow the count.");

    a_tx_low_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(tx_low) |-> raw[TXLO_BIT])
        else $error("Transmit low-level flag missing.");

    a_tx_full_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        !tx_full |=> !raw[TXF_BIT])
        else $error("Transmit full flag stays after the FIFO left full.");

    a_overflow_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        s_ovf_write |=> raw[TXOV_BIT] [*2])
        else $error("Overflow flag not set or not held.");

    a_rx_high_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |-> raw[RXHI_BIT] == $past(rx_high))
        else $error("Receive high-level flag wrong.");

    a_rx_full_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        raw[RXF_BIT] && !rx_read_i |=> raw[RXF_BIT])
        else $error("Receive full flag dropped without a read.");

    a_length_set: assert property (@(posedge clk_i) disable iff (rst_i)
        len_hit |=> raw[LEN_BIT])
        else $error("Length flag not set on the matching byte.");

    a_hold_start: assert property (@(posedge clk_i) disable iff (rst_i)
        hold_want && scl_low |=> scl_oe_o)
        else $error("Clock hold did not start.");

    a_hold_release: assert property (@(posedge clk_i) disable iff (rst_i)
        s_clear_len ##1 !raw[LEN_BIT] |=> !scl_oe_o)
        else $error("Clock hold not released after clear.");

    a_read_req_flush: assert property (@(posedge clk_i) disable iff (rst_i)
        slave_read_req_i |=> raw[RREQ_BIT] && tx_flush_o)
        else $error("Read request not flagged with a flush.");

    a_underflow_end: assert property (@(posedge clk_i) disable iff (rst_i)
        !slave_read_busy_i |=> !raw[RUND_BIT])
        else $error("Underflow flag stays after the read ended.");

    a_write_req_set: assert property (@(posedge clk_i) disable iff (rst_i)
        slave_write_req_i |=> raw[WREQ_BIT])
        else $error("Write request flag not set.");

    a_sticky_keep: assert property (@(posedge clk_i) disable iff (rst_i)
        raw[WREQ_BIT] && !clr[WREQ_BIT] |=> raw[WREQ_BIT])
        else $error("Write request flag lost without a clear.");

    a_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        (mask == ZERO_WORD) |-> !irq_o)
        else $error("Interrupt raised with every mask bit zero.");

    a_rx_empty_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |-> raw[RXE_BIT] == $past(rx_empty))
        else $error("Receive empty flag does not follow the count.");

    a_underflow_set: assert property (@(posedge clk_i) disable iff (rst_i)
        slave_read_busy_i && tx_empty |=> raw[RUND_BIT])
        else $error("Underflow flag missing during a slave read.");

    a_read_req_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        raw[RREQ_BIT] && tx_write_i && !slave_read_req_i |=> !raw[RREQ_BIT])
        else $error("Read request flag stays after a transmit write.");

    a_length_keep: assert property (@(posedge clk_i) disable iff (rst_i)
        raw[LEN_BIT] && !clr[LEN_BIT] |=> raw[LEN_BIT])
        else $error("Length flag lost without a clear.");

endmodule

`default_nettype wire

// >>> tb/scl_far_model.sv
/*
 * Far side of the serial clock: a bus party that clocks only within frames.
 * Assumes the block holds the open-drain pin low through scl_oe_o and scl_o.
 */
`default_nettype none

module scl_far_model (
    input  wire logic run_i,
    input  wire logic oe_i,
    input  wire logic drv_i,
    output logic      scl_o
);
    timeunit 1ns;
    timeprecision 1ps;
    /************************************/
    /* Clock of the far party.          */
    /************************************/
    logic far_clk;
    initial begin
        far_clk = 1'b1;
        forever #32 far_clk = run_i ? ~far_clk : 1'b1;
    end
    // The far party's clock sets the line unless the block drives its low level.
    assign scl_o = (oe_i && !drv_i) ? 1'b0 : far_clk;
endmodule

`default_nettype wire

// >>> tb/tb.sv
/*
 * Self-checking bench of the raw interrupt status block.
 * Assumes the package, the design files and the far clock model compile first.
 */
`default_nettype none

module tb
    import i2c_irq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    /************************************/
    /* Stimulus, scenarios and verdict. */
    /************************************/
    logic        clk_i, rst_i, cyc, stb, we, txw, rxr, rxb, mro, swo, srq, swq, sbusy, run;
    logic [7:0]  adr;
    logic [31:0] dat, q;
    logic [3:0]  sel;
    logic [4:0]  txc, rxc;
    wire logic [31:0] dat_o;
    wire logic   ack, scl_o, scl_oe, flush, irq, scl_line;
    int          n_mismatch, num_checks, i;

    i2c_raw_interrupt_status dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
        .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_ack_o(ack), .tx_count_i(txc), .rx_count_i(rxc),
        .tx_write_i(txw), .rx_read_i(rxr), .rx_byte_i(rxb), .master_read_op_i(mro),
        .slave_write_op_i(swo), .slave_read_req_i(srq), .slave_write_req_i(swq),
        .slave_read_busy_i(sbusy), .scl_i(scl_line), .scl_o(scl_o), .scl_oe_o(scl_oe),
        .tx_flush_o(flush), .irq_o(irq));
    scl_far_model far_u (.run_i(run), .oe_i(scl_oe), .drv_i(scl_o), .scl_o(scl_line));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask

    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
        for (k = 0; k < 20; k++) begin
            @(posedge clk_i);
            if (ack === 1'b1) break;
        end
        if (k == 20) begin
            n_mismatch++;
            give_verdict();
        end else begin
            q = dat_o;
            cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        end
    endtask

    task rb(input int b, input logic e);
        wb(1'b0, RAW_ADDR, ZERO_WORD);
        chk("raw flag", {31'h0, q[b]}, {31'h0, e});
    endtask

    task wait_oe(input logic e);
        for (i = 0; i < 200 && scl_oe !== e; i++) @(posedge clk_i);
        chk("clock hold", {31'h0, scl_oe}, {31'h0, e});
        if (scl_oe !== e) give_verdict();
    endtask

    task t_regs;
        rb(TXE_BIT, 1'b1);
        rb(RXE_BIT, 1'b1);
        wb(1'b0, MASK_ADDR, ZERO_WORD);
        chk("mask reset", q, ZERO_WORD);
        wb(1'b0, 8'h3c, ZERO_WORD);
        chk("unmapped", q, ZERO_WORD);
        wb(1'b1, RAW_ADDR, 32'hffff_ffff);
        rb(TXOV_BIT, 1'b0);
        wb(1'b1, TXTHR_ADDR, 32'h0000_0003);
        wb(1'b1, RXTHR_ADDR, 32'h0000_0004);
    endtask

    task t_tx;
        for (int n = 0; n <= 16; n++) begin
            @(posedge clk_i) txc <= n[4:0];
            rb(TXE_BIT, n == 0);
            rb(TXLO_BIT, n <= 3);
            rb(TXF_BIT, n == 16);
            rb(TXOV_BIT, 1'b0);
        end
        @(posedge clk_i) txw <= 1'b1;
        @(posedge clk_i) txw <= 1'b0;
        @(posedge clk_i) txc <= 5'h5;
        rb(TXOV_BIT, 1'b1);
        wb(1'b1, CTRL_ADDR, 32'h0000_0001);
        rb(TXOV_BIT, 1'b1);
        wb(1'b1, CLR_ADDR, 32'h0000_0008);
        rb(TXOV_BIT, 1'b0);
    endtask

    task t_rx;
        for (int n = 0; n <= 16; n++) begin
            @(posedge clk_i) rxc <= n[4:0];
            rb(RXE_BIT, n == 0);
            rb(RXHI_BIT, n >= 4);
            rb(RXF_BIT, n == 16);
        end
        @(posedge clk_i) rxc <= 5'hf;
        rb(RXF_BIT, 1'b1);
        @(posedge clk_i) rxr <= 1'b1;
        @(posedge clk_i) rxr <= 1'b0;
        rb(RXF_BIT, 1'b0);
    endtask

    task t_slave;
        @(posedge clk_i) srq <= 1'b1;
        @(posedge clk_i) srq <= 1'b0;
        @(negedge clk_i) chk("flush", {31'h0, flush}, 32'h0000_0001);
        @(negedge clk_i) chk("flush end", {31'h0, flush}, 32'h0000_0000);
        rb(RREQ_BIT, 1'b1);
        @(posedge clk_i) txw <= 1'b1;
        @(posedge clk_i) txw <= 1'b0;
        rb(RREQ_BIT, 1'b0);
        @(posedge clk_i) begin
            sbusy <= 1'b1;
            txc <= 5'h0;
        end
        rb(RUND_BIT, 1'b1);
        @(posedge clk_i) txc <= 5'h1;
        rb(RUND_BIT, 1'b0);
        @(posedge clk_i) txc <= 5'h0;
        rb(RUND_BIT, 1'b1);
        @(posedge clk_i) sbusy <= 1'b0;
        rb(RUND_BIT, 1'b0);
        @(posedge clk_i) swq <= 1'b1;
        @(posedge clk_i) swq <= 1'b0;
        repeat (4) @(posedge clk_i);
        rb(WREQ_BIT, 1'b1);
        wb(1'b1, MASK_ADDR, 32'h0004_0000);
        @(negedge clk_i) chk("irq on", {31'h0, irq}, 32'h0000_0001);
        wb(1'b1, MASK_ADDR, ZERO_WORD);
        @(negedge clk_i) chk("irq off", {31'h0, irq}, 32'h0000_0000);
        wb(1'b1, CLR_ADDR, 32'h0004_0000);
        rb(WREQ_BIT, 1'b0);
    endtask

    task t_len;
        wb(1'b1, CTRL_ADDR, 32'h0000_0002);
        wb(1'b1, SLEN_ADDR, 32'h0000_0003);
        @(posedge clk_i) begin
            swo <= 1'b1;
            run <= 1'b1;
        end
        for (int n = 1; n <= 3; n++) begin
            @(posedge clk_i) rxb <= 1'b1;
            @(posedge clk_i) rxb <= 1'b0;
            repeat (2) @(posedge clk_i);
            if (n == 2) rb(LEN_BIT, 1'b0);
        end
        rb(LEN_BIT, 1'b1);
        wait_oe(1'b1);
        chk("scl line", {31'h0, scl_line}, 32'h0000_0000);
        @(posedge clk_i) rxr <= 1'b1;
        @(posedge clk_i) rxr <= 1'b0;
        wb(1'b1, SLEN_ADDR, 32'h0000_0003);
        wb(1'b1, CLR_ADDR, 32'h0000_8000);
        wait_oe(1'b0);
        rb(LEN_BIT, 1'b0);
        @(posedge clk_i) begin
            swo <= 1'b0;
            run <= 1'b0;
        end
        wb(1'b1, CTRL_ADDR, ZERO_WORD);
        wb(1'b1, MLEN_ADDR, 32'h0000_0002);
        @(posedge clk_i) mro <= 1'b1;
        repeat (2) begin
            @(posedge clk_i) rxb <= 1'b1;
            @(posedge clk_i) rxb <= 1'b0;
        end
        repeat (2) @(posedge clk_i);
        rb(LEN_BIT, 1'b1);
        @(posedge clk_i) mro <= 1'b0;
        wb(1'b1, CLR_ADDR, 32'h0000_8000);
        rb(LEN_BIT, 1'b0);
    endtask

    initial begin
        {cyc, stb, we, txw, rxr, rxb, mro, swo, srq, swq, sbusy, run} = '0;
        adr = 8'h00;
        dat = ZERO_WORD;
        sel = 4'h0;
        txc = 5'h0;
        rxc = 5'h0;
        n_mismatch = 0;
        num_checks = 0;
        rst_i = 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_tx();
        t_rx();
        t_slave();
        t_len();
        give_verdict();
    end
endmodule

`default_nettype wire
